// [src/irq_vector_ctrl.sv]
// interrupt and exception arbiter with vector mapping and low-power wake-up
// Notes on behaviour
// - any reset takes vector 0000, rank zero
// - five exceptions at 0004 onward, rank one
// - sixteen traps vector 0040 to 007C, rank one
// - first seven event sources fixed vectors, ranks
// - serial ports vector 00A0 to 00AC, ranks 9-12
// - counter channels 00C0-00D0, two-wire at 00D4
// - four-bit priority per source, two per register except group a register 3, which holds one
// - request needs own flag and own enable
// - timer 2 overflow or external flag requests
// - counter summary plus five separate channel interrupts
// - seven soft interrupts, fixed priority equals index
// - exactly seventeen hardware event sources
// - power-down wakes only on reset or pins
// - pin wake needs enable and priority above mask
// - idle keeps peripherals running to wake core
// - power-down keeps the held grant untouched; the pin synchronisers still run
// - two-wire needs global and own enable
`timescale 1ns/10ps
module irq_vector_ctrl
	import irq_vector_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic reset_event_i,
	input wire logic [NUM_EXC-1:0] exception_req_i,
	input wire logic trap_req_i,
	input wire logic [3:0] trap_num_i,
	input wire evt_flags_t evt_flags_i,
	input wire evt_enables_t evt_enables_i,
	input wire logic [7:0] priority_group_a_i [6],
	input wire logic [7:0] priority_group_b_i [3],
	input wire logic [NUM_SOFT:1] soft_request_i,
	input wire logic [NUM_SOFT:1] soft_enable_i,
	input wire logic [PRIO_W-1:0] exec_priority_mask_i,
	input wire logic ext_irq_pin0_i,
	input wire logic ext_irq_pin1_i,
	input wire logic idle_enter_i,
	input wire logic powerdown_enter_i,
	input wire logic grant_ack_i,
	output grant_t grant_o,
	output power_mode_t power_mode_o,
	output logic osc_run_o,
	output logic core_run_o,
	output logic periph_run_o,
	output logic wake_o
);
	logic [PRIO_W-1:0] evt_prio [NUM_EVT]; // per-source priority fields
	logic [NUM_EVT-1:0] evt_raw; // ungated flag view, one bit per source
	logic [NUM_EVT-1:0] evt_req; // gated event requests
	logic [NUM_EVT-1:0] evt_en; // per-source enable view
	grant_t best; // combinational winner
	grant_t grant_r; // registered grant
	power_mode_t mode_r; // power state
	power_mode_t mode_nxt; // next power state
	logic pin0_s1_r; // pin synchroniser stage one
	logic pin0_s2_r; // pin synchroniser stage two
	logic pin1_s1_r;
	logic pin1_s2_r;
	logic pin_wake; // qualified pin wake-up
	logic evt_wake; // any serviceable request

	// vector slot n above a base, four bytes apart
	function automatic logic [VEC_W-1:0] slot_vec(input logic [VEC_W-1:0] base,
			input logic [VEC_W-1:0] idx);
		slot_vec = base + VEC_W'(idx * VEC_SLOT);
	endfunction : slot_vec

	// true when candidate beats incumbent: higher priority, then lower rank
	function automatic logic beats(input logic [PRIO_W-1:0] cp, input logic [RANK_W-1:0] cr,
			input logic [PRIO_W-1:0] bp, input logic [RANK_W-1:0] br);
		beats = (cp > bp) || ((cp == bp) && (cr < br));
	endfunction : beats

	// nibble fields of the priority registers
	prio_nibble_split u_split (
		.priority_group_a_i(priority_group_a_i),
		.priority_group_b_i(priority_group_b_i),
		.evt_prio_o(evt_prio)
	);

	// enable view, one bit per source, all seventeen
	always_comb begin
		evt_en[EV_EXT0] = evt_enables_i.ext_irq0_enable;
		evt_en[EV_TMR0] = evt_enables_i.timer0_irq_enable;
		evt_en[EV_EXT1] = evt_enables_i.ext_irq1_enable;
		evt_en[EV_TMR1] = evt_enables_i.timer1_irq_enable;
		evt_en[EV_TMR2] = evt_enables_i.timer2_irq_enable;
		evt_en[EV_CNTA] = evt_enables_i.counter_array_irq_enable;
		evt_en[EV_CONV] = evt_enables_i.converter_irq_enable;
		evt_en[EV_S0RX] = evt_enables_i.serial0_rx_enable;
		evt_en[EV_S0TX] = evt_enables_i.serial0_tx_enable;
		evt_en[EV_S1RX] = evt_enables_i.serial1_rx_enable;
		evt_en[EV_S1TX] = evt_enables_i.serial1_tx_enable;
		for (int i = 0; i < NUM_CCH; i++) begin
			evt_en[EV_CCH0+i] = evt_enables_i.counter_channel_enable[i];
		end
		// two-wire also needs the global enable
		evt_en[EV_TWOW] = evt_enables_i.twowire_irq_enable
			&& evt_enables_i.global_irq_enable;
	end

	// flag view in source order; gating happens below
	always_comb begin
		evt_raw[EV_EXT0] = evt_flags_i.ext_irq0_flag;
		evt_raw[EV_TMR0] = evt_flags_i.timer0_overflow_flag;
		evt_raw[EV_EXT1] = evt_flags_i.ext_irq1_flag;
		evt_raw[EV_TMR1] = evt_flags_i.timer1_overflow_flag;
		// one vector and one enable for both timer 2 causes
		evt_raw[EV_TMR2] = evt_flags_i.timer2_overflow_flag
			|| evt_flags_i.timer2_external_flag;
		// summary sees every channel flag plus the counter overflow
		evt_raw[EV_CNTA] = (|evt_flags_i.counter_channel_flag)
			|| evt_flags_i.counter_array_overflow_flag;
		evt_raw[EV_CONV] = evt_flags_i.converter_done_flag;
		evt_raw[EV_S0RX] = evt_flags_i.serial0_rx_flag;
		evt_raw[EV_S0TX] = evt_flags_i.serial0_tx_flag;
		evt_raw[EV_S1RX] = evt_flags_i.serial1_rx_flag;
		evt_raw[EV_S1TX] = evt_flags_i.serial1_tx_flag;
		for (int i = 0; i < NUM_CCH; i++) begin
			evt_raw[EV_CCH0+i] = evt_flags_i.counter_channel_flag[i];
		end
		evt_raw[EV_TWOW] = evt_flags_i.twowire_flag;
	end

	// flag and enable together make a request
	assign evt_req = evt_raw & evt_en;

	// arbiter: resets first, then exceptions and traps, then events by priority
	always_comb begin
		best = '0;
		if (reset_event_i) begin
			best.valid = 1'b1;
			best.vector = VEC_RESET;
			best.rank = RANK_RESET;
		end else if (|exception_req_i) begin
			best.valid = 1'b1;
			best.rank = RANK_EXC;
			// lowest slot of the pending set wins within the shared rank
			for (int i = NUM_EXC - 1; i >= 0; i--) begin
				if (exception_req_i[i]) begin
					best.vector = slot_vec(VEC_EXC_BASE, VEC_W'(i));
				end
			end
		end else if (trap_req_i) begin
			best.valid = 1'b1;
			best.rank = RANK_EXC;
			best.vector = slot_vec(VEC_TRAP_BASE, VEC_W'(trap_num_i));
		end else begin
			best.rank = RANK_SOFT;
			// events must beat the execution mask to be taken
			best.prio = exec_priority_mask_i;
			// ascending scan with strict beat keeps the lowest rank on ties
			for (int i = 0; i < NUM_EVT; i++) begin
				// strict compare with the mask; a tie with the mask must not win on rank
				if (evt_req[i] && (evt_prio[i] > exec_priority_mask_i)
						&& beats(evt_prio[i], EVT_RANK[i], best.prio, best.rank)) begin
					best.valid = 1'b1;
					best.vector = EVT_VEC[i];
					best.rank = EVT_RANK[i];
					best.prio = evt_prio[i];
				end
			end
			for (int s = 1; s <= NUM_SOFT; s++) begin
				if (soft_request_i[s] && soft_enable_i[s]
						&& (PRIO_W'(s) > exec_priority_mask_i)
						&& beats(PRIO_W'(s), RANK_SOFT, best.prio, best.rank)) begin
					best.valid = 1'b1;
					best.vector = slot_vec(VEC_SOFT_BASE, VEC_W'(s - 1));
					best.rank = RANK_SOFT;
					best.prio = PRIO_W'(s);
				end
			end
		end
	end

	// grant register: held until the core acknowledges, frozen in power-down
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			grant_r <= '0;
		end else if (mode_r == PM_DOWN) begin
			grant_r <= grant_r;
		end else if (!grant_r.valid || grant_ack_i) begin
			grant_r <= best;
		end
	end

	// external pins cross into the core clock through two flops
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			pin0_s1_r <= 1'b0;
			pin0_s2_r <= 1'b0;
			pin1_s1_r <= 1'b0;
			pin1_s2_r <= 1'b0;
		end else begin
			pin0_s1_r <= ext_irq_pin0_i;
			pin0_s2_r <= pin0_s1_r;
			pin1_s1_r <= ext_irq_pin1_i;
			pin1_s2_r <= pin1_s1_r;
		end
	end

	// pin wake qualified by enable and priority above the mask
	assign pin_wake = (pin0_s2_r && evt_enables_i.ext_irq0_enable
			&& (evt_prio[EV_EXT0] > exec_priority_mask_i))
		|| (pin1_s2_r && evt_enables_i.ext_irq1_enable
			&& (evt_prio[EV_EXT1] > exec_priority_mask_i));
	assign evt_wake = best.valid;

	// power mode next state; reset wakes through rst_i and reset_event_i
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			PM_RUN: begin
				if (powerdown_enter_i) begin
					mode_nxt = PM_DOWN;
				end else if (idle_enter_i) begin
					mode_nxt = PM_IDLE;
				end
			end
			PM_IDLE: begin
				// live peripherals may raise any request
				if (evt_wake) begin
					mode_nxt = PM_RUN;
				end
			end
			PM_DOWN: begin
				// only the pins or a reset; other flags cannot move with the clock stopped
				if (pin_wake || reset_event_i) begin
					mode_nxt = PM_RUN;
				end
			end
			default: begin
				mode_nxt = PM_RUN;
			end
		endcase
	end

	// power mode register
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			mode_r <= PM_RUN;
		end else begin
			mode_r <= mode_nxt;
		end
	end

	// outputs; the wake detector itself stays on the unstopped clock, a limitation
	assign grant_o = grant_r;
	assign power_mode_o = mode_r;
	assign osc_run_o = (mode_r != PM_DOWN);
	assign core_run_o = (mode_r == PM_RUN);
	assign periph_run_o = (mode_r != PM_DOWN);
	assign wake_o = (mode_r != PM_RUN) && (mode_nxt == PM_RUN);
endmodule : irq_vector_ctrl

// [src/irq_vector_pkg.sv]
// shared constants and types for the interrupt and exception vectoring block
package irq_vector_pkg;
	localparam int NUM_EVT = 17;
	localparam int NUM_SOFT = 7;
	localparam int NUM_TRAP = 16;
	localparam int PRIO_W = 4;
	localparam int RANK_W = 5;
	localparam int VEC_W = 16;
	localparam int NUM_EXC = 5;
	// exception sources in vector order: breakpoint, trace, stack overflow, divide, user return
	localparam logic [VEC_W-1:0] VEC_RESET = 16'h0000;
	localparam logic [VEC_W-1:0] VEC_EXC_BASE = 16'h0004;
	localparam logic [VEC_W-1:0] VEC_TRAP_BASE = 16'h0040;
	localparam logic [VEC_W-1:0] VEC_SOFT_BASE = 16'h0100;
	localparam logic [VEC_W-1:0] VEC_SLOT = 16'h0004;
	localparam logic [RANK_W-1:0] RANK_RESET = 5'h00;
	localparam logic [RANK_W-1:0] RANK_EXC = 5'h01;
	localparam logic [RANK_W-1:0] RANK_SOFT = 5'h1f;
	// event source indices
	localparam int EV_EXT0 = 0;
	localparam int EV_TMR0 = 1;
	localparam int EV_EXT1 = 2;
	localparam int EV_TMR1 = 3;
	localparam int EV_TMR2 = 4;
	localparam int EV_CNTA = 5;
	localparam int EV_CONV = 6;
	localparam int EV_S0RX = 7;
	localparam int EV_S0TX = 8;
	localparam int EV_S1RX = 9;
	localparam int EV_S1TX = 10;
	localparam int EV_CCH0 = 11;
	localparam int EV_TWOW = 16;
	localparam int NUM_CCH = 5;
	// vector address of each event source
	localparam logic [VEC_W-1:0] EVT_VEC [NUM_EVT] = '{
		16'h0080, 16'h0084, 16'h0088, 16'h008c, 16'h0090, 16'h0094, 16'h0098,
		16'h00a0, 16'h00a4, 16'h00a8, 16'h00ac,
		16'h00c0, 16'h00c4, 16'h00c8, 16'h00cc, 16'h00d0, 16'h00d4};
	// arbitration rank of each event source
	localparam logic [RANK_W-1:0] EVT_RANK [NUM_EVT] = '{
		5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
		5'h09, 5'h0a, 5'h0b, 5'h0c,
		5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};
	// request flags of the event sources
	typedef struct packed {
		logic ext_irq0_flag;
		logic ext_irq1_flag;
		logic timer0_overflow_flag;
		logic timer1_overflow_flag;
		logic timer2_overflow_flag;
		logic timer2_external_flag;
		logic counter_array_overflow_flag;
		logic [NUM_CCH-1:0] counter_channel_flag;
		logic converter_done_flag;
		logic serial0_rx_flag;
		logic serial0_tx_flag;
		logic serial1_rx_flag;
		logic serial1_tx_flag;
		logic twowire_flag;
	} evt_flags_t;
	// enable bits of the event sources
	typedef struct packed {
		logic global_irq_enable;
		logic ext_irq0_enable;
		logic ext_irq1_enable;
		logic timer0_irq_enable;
		logic timer1_irq_enable;
		logic timer2_irq_enable;
		logic counter_array_irq_enable;
		logic [NUM_CCH-1:0] counter_channel_enable;
		logic converter_irq_enable;
		logic serial0_rx_enable;
		logic serial0_tx_enable;
		logic serial1_rx_enable;
		logic serial1_tx_enable;
		logic twowire_irq_enable;
	} evt_enables_t;
	// the granted request handed to the core
	typedef struct packed {
		logic valid;
		logic [VEC_W-1:0] vector;
		logic [RANK_W-1:0] rank;
		logic [PRIO_W-1:0] prio;
	} grant_t;
	typedef enum logic [1:0] {
		PM_RUN = 2'b00,
		PM_IDLE = 2'b01,
		PM_DOWN = 2'b10
	} power_mode_t;
endpackage : irq_vector_pkg

// [src/prio_nibble_split.sv]
// splits the packed priority registers into one field per event source
`timescale 1ns/10ps
module prio_nibble_split
	import irq_vector_pkg::*;
(
	input wire logic [7:0] priority_group_a_i [6],
	input wire logic [7:0] priority_group_b_i [3],
	output logic [PRIO_W-1:0] evt_prio_o [NUM_EVT]
);
	// two fields per register except group a register 3 (converter only), low nibble first
	always_comb begin
		evt_prio_o[EV_EXT0] = priority_group_a_i[0][3:0];
		evt_prio_o[EV_TMR0] = priority_group_a_i[0][7:4];
		evt_prio_o[EV_EXT1] = priority_group_a_i[1][3:0];
		evt_prio_o[EV_TMR1] = priority_group_a_i[1][7:4];
		evt_prio_o[EV_TMR2] = priority_group_a_i[2][3:0];
		evt_prio_o[EV_CNTA] = priority_group_a_i[2][7:4];
		evt_prio_o[EV_CONV] = priority_group_a_i[3][3:0];
		evt_prio_o[EV_S0RX] = priority_group_a_i[4][3:0];
		evt_prio_o[EV_S0TX] = priority_group_a_i[4][7:4];
		evt_prio_o[EV_S1RX] = priority_group_a_i[5][3:0];
		evt_prio_o[EV_S1TX] = priority_group_a_i[5][7:4];
		evt_prio_o[EV_CCH0] = priority_group_b_i[0][3:0];
		evt_prio_o[EV_CCH0+1] = priority_group_b_i[0][7:4];
		evt_prio_o[EV_CCH0+2] = priority_group_b_i[1][3:0];
		evt_prio_o[EV_CCH0+3] = priority_group_b_i[1][7:4];
		evt_prio_o[EV_CCH0+4] = priority_group_b_i[2][3:0];
		evt_prio_o[EV_TWOW] = priority_group_b_i[2][7:4];
	end
endmodule : prio_nibble_split

// [testbench/core_seq_model.sv]
// core sequencer that takes granted vectors
`timescale 1ns/10ps
module core_seq_model
	import irq_vector_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire grant_t grant_i,
	input wire logic ack_en_i,
	input wire logic slow_i,
	output logic grant_ack_o,
	output logic [VEC_W-1:0] taken_vec_o
);
	logic [1:0] wait_r; // cycles waited before a slow take
	// one-cycle take pulse, three cycles late when slow
	always_ff @(posedge core_clk_i or posedge rst_i) begin
		if (rst_i) begin
			grant_ack_o <= 1'b0;
			wait_r <= 2'h0;
			taken_vec_o <= 16'h0000;
		end else if (grant_ack_o) begin
			grant_ack_o <= 1'b0; // grant reloads here, never take it twice
			wait_r <= 2'h0;
		end else if (grant_i.valid && ack_en_i) begin
			if (!slow_i || wait_r == 2'h3) begin
				grant_ack_o <= 1'b1;
				taken_vec_o <= grant_i.vector;
			end else begin
				wait_r <= wait_r + 2'h1;
			end
		end
	end
endmodule : core_seq_model

// [testbench/exception_and_event_interrupt_vectoring_tb_top.sv]
// self-checking bench for the vectoring block
`timescale 1ns/10ps
module exception_and_event_interrupt_vectoring_tb_top
	import irq_vector_pkg::*;
;
	`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
		$display("ERROR t=%0t got %h exp %h", $time, g, e); end end
	// flag and enable bit of each source inside the packed structs
	localparam int FBIT [NUM_EVT] = '{17, 15, 16, 14, 13, 11, 5, 4, 3, 2, 1, 6, 7, 8, 9, 10, 0};
	localparam int EBIT [NUM_EVT] = '{16, 14, 15, 13, 12, 11, 5, 4, 3, 2, 1, 6, 7, 8, 9, 10, 0};
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic rst_evt = 1'b0, trap_req = 1'b0, pin0 = 1'b0, pin1 = 1'b0, idle_in = 1'b0;
	logic pd_in = 1'b0, ack_en = 1'b0, slow = 1'b0, ack, osc, core_run, periph, wake;
	logic [NUM_EXC-1:0] exc = '0;
	logic [3:0] trap_num = 4'h0;
	logic [3:0] mask = 4'h0;
	evt_flags_t flags = '0;
	evt_enables_t ens = '0;
	logic [7:0] pa [6] = '{default: 8'h00};
	logic [7:0] pb [3] = '{default: 8'h00};
	logic [NUM_SOFT:1] sreq = '0, sen = '1;
	logic [VEC_W-1:0] taken;
	grant_t grant;
	power_mode_t mode;
	int err_count = 0;
	int comparisons = 0;
	always #4 clk = ~clk;
	irq_vector_ctrl u_dut (.core_clk_i(clk), .rst_i(rst), .reset_event_i(rst_evt),
		.exception_req_i(exc), .trap_req_i(trap_req), .trap_num_i(trap_num),
		.evt_flags_i(flags), .evt_enables_i(ens), .priority_group_a_i(pa),
		.priority_group_b_i(pb), .soft_request_i(sreq), .soft_enable_i(sen),
		.exec_priority_mask_i(mask), .ext_irq_pin0_i(pin0), .ext_irq_pin1_i(pin1),
		.idle_enter_i(idle_in), .powerdown_enter_i(pd_in), .grant_ack_i(ack),
		.grant_o(grant), .power_mode_o(mode), .osc_run_o(osc), .core_run_o(core_run),
		.periph_run_o(periph), .wake_o(wake));
	core_seq_model u_core (.core_clk_i(clk), .rst_i(rst), .grant_i(grant),
		.ack_en_i(ack_en), .slow_i(slow), .grant_ack_o(ack), .taken_vec_o(taken));
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : tally_and_finish
	// drop every request; the held grant stays until taken
	task automatic clr();
		rst_evt <= 1'b0;
		exc <= '0;
		trap_req <= 1'b0;
		flags <= '0;
		sreq <= '0;
		mask <= 4'h0;
		pin0 <= 1'b0;
	endtask : clr
	// judge the grant, withdraw requests, then let the core take it
	task automatic serve(input logic [VEC_W-1:0] v, input logic [RANK_W-1:0] r,
		input logic [3:0] p);
		int n;
		n = 0;
		@(negedge clk);
		while (grant.valid !== 1'b1 && n < 12) begin
			@(negedge clk);
			n++;
		end
		`CHK(grant.vector, v)
		`CHK(grant.rank, r)
		if (r > 5'h01)
			`CHK(grant.prio, p)
		@(posedge clk);
		clr();
		ack_en <= 1'b1;
		n = 0;
		while (grant.valid !== 1'b0 && n < 12) begin
			@(negedge clk);
			n++;
		end
		`CHK(taken, v)
		@(posedge clk);
		ack_en <= 1'b0;
	endtask : serve
	// priority nibble of one source: two sources per group register, one in pa[3]
	task automatic set_prio(input int s, input logic [3:0] p);
		int g;
		int h;
		g = (s < 7) ? s >> 1 : (s < 11) ? (s + 1) >> 1 : (s - 11) >> 1;
		h = (s < 7) ? s & 1 : (s < 11) ? (s + 1) & 1 : (s - 11) & 1;
		if (s < 11)
			pa[g][4*h +: 4] <= p;
		else
			pb[g][4*h +: 4] <= p;
	endtask : set_prio
	// one flag: refused without its enable (two-wire: without the global enable), then granted at its slot
	task automatic fire(input int f, input int e, input int s, input logic [3:0] p,
		input logic [VEC_W-1:0] v, input logic [RANK_W-1:0] r);
		@(posedge clk);
		slow <= s[0];
		set_prio(s, p);
		flags <= evt_flags_t'(18'h0_0001 << f);
		ens <= evt_enables_t'((s == 16) ? 18'h0_0001 : 18'h2_0000);
		repeat (3) @(negedge clk);
		`CHK(grant.valid, 1'b0)
		@(posedge clk);
		ens <= evt_enables_t'((18'h0_0001 << e) | 18'h2_0000);
		serve(v, r, p);
		set_prio(s, 4'h0);
	endtask : fire
	// all seventeen sources, then the shared timer and counter requests
	task automatic t_events();
		for (int i = 0; i < NUM_EVT; i++)
			fire(FBIT[i], EBIT[i], i, 4'(i % 15 + 1), (i < 7) ? 16'h0080 + 16'(4 * i) :
				(i < 11) ? 16'h00a0 + 16'(4 * (i - 7)) : 16'h00c0 + 16'(4 * (i - 11)),
				5'(i < 11 ? i + 2 : i + 6));
		fire(12, 12, 4, 4'h9, 16'h0090, 5'h06);
		fire(6, 11, 5, 4'h3, 16'h0094, 5'h07);
	endtask : t_events
	// soft requests refused at the mask, granted just above it
	task automatic t_soft();
		for (int s = 1; s <= NUM_SOFT; s++) begin
			@(posedge clk);
			mask <= 4'(s);
			sreq <= 7'h01 << (s - 1);
			repeat (3) @(negedge clk);
			`CHK(grant.valid, 1'b0)
			@(posedge clk);
			mask <= 4'(s - 1);
			serve(16'h0100 + 16'(4 * (s - 1)), RANK_SOFT, 4'(s));
		end
	endtask : t_soft
	// equal priorities, then exceptions and traps over pending events
	task automatic t_order();
		@(posedge clk);
		pa <= '{default: 8'h55};
		flags <= evt_flags_t'(18'h2_4000);
		ens <= '1;
		sreq <= 7'h10;
		mask <= 4'h5;
		repeat (3) @(negedge clk);
		`CHK(grant.valid, 1'b0)
		@(posedge clk);
		mask <= 4'h0;
		serve(16'h0080, 5'h02, 4'h5);
		flags <= evt_flags_t'(18'h0_4000);
		sreq <= 7'h10;
		serve(16'h008c, 5'h05, 4'h5);
		for (int e = 0; e < NUM_EXC; e++) begin
			exc <= 5'h1f << e;
			trap_req <= 1'b1;
			flags <= evt_flags_t'(18'h2_0000);
			serve(16'h0004 + 16'(4 * e), 5'h01, 4'h0);
		end
		for (int n = 0; n < NUM_TRAP; n++) begin
			trap_req <= 1'b1;
			trap_num <= 4'(n);
			flags <= evt_flags_t'(18'h2_0000);
			serve(16'h0040 + 16'(4 * n), 5'h01, 4'h0);
		end
		rst_evt <= 1'b1;
		exc <= 5'h01;
		serve(16'h0000, 5'h00, 4'h0);
	endtask : t_order
	// idle wakes on a request; power-down only on a qualified pin
	task automatic t_power();
		idle_in <= 1'b1;
		pa <= '{default: 8'h00};
		@(posedge clk);
		idle_in <= 1'b0;
		@(negedge clk);
		`CHK(mode, PM_IDLE)
		`CHK({core_run, periph}, 2'b01)
		@(posedge clk);
		pa[0] <= 8'h10;
		flags <= evt_flags_t'(18'h0_8000);
		serve(16'h0084, 5'h03, 4'h1);
		@(negedge clk);
		`CHK(mode, PM_RUN)
		@(posedge clk);
		pd_in <= 1'b1;
		@(posedge clk);
		pd_in <= 1'b0;
		pa[0] <= 8'h32;
		mask <= 4'h2;
		pin0 <= 1'b1;
		flags <= evt_flags_t'(18'h0_8000);
		repeat (6) @(negedge clk);
		`CHK(mode, PM_DOWN)
		`CHK(osc, 1'b0)
		`CHK({core_run, periph}, 2'b00)
		`CHK(grant.valid, 1'b0)
		@(posedge clk);
		mask <= 4'h1;
		@(negedge clk);
		`CHK(wake, 1'b1)
		serve(16'h0084, 5'h03, 4'h3);
		@(negedge clk);
		`CHK(mode, PM_RUN)
	endtask : t_power
	initial begin
		#100000;
		err_count++;
		tally_and_finish();
	end
	initial begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		t_events();
		$display("event sources done");
		t_soft();
		$display("soft requests done");
		t_order();
		$display("ordering done");
		t_power();
		$display("power modes done");
		tally_and_finish();
	end
endmodule : exception_and_event_interrupt_vectoring_tb_top
bind irq_vector_ctrl irq_vector_chk u_chk (.*);

// [testbench/irq_vector_chk.sv]
// port-level checks on the vectoring block
`timescale 1ns/10ps
module irq_vector_chk
	import irq_vector_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic reset_event_i,
	input wire logic [NUM_EXC-1:0] exception_req_i,
	input wire logic trap_req_i,
	input wire logic [3:0] trap_num_i,
	input wire logic [PRIO_W-1:0] exec_priority_mask_i,
	input wire logic ext_irq_pin0_i,
	input wire logic ext_irq_pin1_i,
	input wire logic powerdown_enter_i,
	input wire logic grant_ack_i,
	input wire grant_t grant_o,
	input wire power_mode_t power_mode_o,
	input wire logic osc_run_o,
	input wire logic core_run_o,
	input wire logic periph_run_o,
	input wire logic wake_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	// edge at which a fresh winner is loaded
	sequence s_load;
		(!grant_o.valid || grant_ack_i) && power_mode_o != PM_DOWN;
	endsequence
	// run mode asked to stop the oscillator
	sequence s_enter_down;
		power_mode_o == PM_RUN && powerdown_enter_i && !reset_event_i;
	endsequence
	a_reset_first: assert property (s_load ##0 reset_event_i |=>
		grant_o.valid && grant_o.vector == 16'h0000 && grant_o.rank == 5'h00)
		else $error("reset not granted at slot zero");
	a_exc_slot: assert property (s_load ##0 !reset_event_i && exception_req_i[0] |=>
		grant_o.vector == 16'h0004 && grant_o.rank == 5'h01)
		else $error("breakpoint slot wrong");
	a_trap_slot: assert property (s_load ##0 !reset_event_i && exception_req_i == '0
		&& trap_req_i |=> grant_o.rank == 5'h01
		&& grant_o.vector == 16'h0040 + {10'h000, $past(trap_num_i), 2'b00})
		else $error("trap slot wrong");
	a_prio_mask: assert property ($changed(grant_o) && grant_o.valid
		&& grant_o.rank > 5'h01 |-> grant_o.prio > $past(exec_priority_mask_i))
		else $error("grant at or below mask");
	a_grant_holds: assert property (grant_o.valid && !grant_ack_i |=> $stable(grant_o))
		else $error("grant changed before take");
	a_down_freeze: assert property (power_mode_o == PM_DOWN |=> $stable(grant_o))
		else $error("grant moved in power-down");
	a_enter_down: assert property (s_enter_down |=> power_mode_o == PM_DOWN
		&& !osc_run_o && !core_run_o && !periph_run_o)
		else $error("power-down entry wrong");
	a_idle_runs: assert property (power_mode_o == PM_IDLE |-> osc_run_o
		&& periph_run_o && !core_run_o)
		else $error("idle run outputs wrong");
	a_wake_cause: assert property (power_mode_o == PM_DOWN && wake_o |-> reset_event_i
		|| $past(ext_irq_pin0_i, 2) || $past(ext_irq_pin1_i, 2))
		else $error("power-down left without cause");
	a_wake_resume: assert property (power_mode_o != PM_RUN && wake_o |=>
		power_mode_o == PM_RUN && core_run_o)
		else $error("wake did not resume");
endmodule : irq_vector_chk
